// File: hdl/misc_regs.svh
// register map, field positions, reset values and timing counts
`ifndef MISC_REGS_SVH
`define MISC_REGS_SVH
`define MISC_GIE_ADDR 8'h20
`define MISC_EPEN_ADDR 8'h21
`define MISC_PSC_ADDR 8'hff
`define MISC_PSC_POR 8'h11
`define MISC_PSC_WDT 8'h41
`define MISC_RUN 0
`define MISC_STEP 1
`define MISC_GIE 2
`define MISC_SUSP 3
`define MISC_PUP 4
`define MISC_BUSRST 5
`define MISC_WDT 6
`define MISC_PEND 7
`define MISC_CLK_PS 5000
`define MISC_SE0_NS 8000
`define MISC_SE0_CYC ((`MISC_SE0_NS * 1000 + `MISC_CLK_PS - 1) / `MISC_CLK_PS)
`define MISC_WAKE_SHORT_NS 128000
`define MISC_WAKE_LONG_NS 96000000
`define MISC_CALL_CYC 10
`define MISC_JMP_CYC 5
`endif

// File: hdl/misc_pkg.sv
// types shared by the status and interrupt control block
package misc_pkg;
  typedef struct packed {
    logic last;
    logic halt;
    logic di;
    logic ei;
    logic irq_return_instruction;
  } misc_cpu_t;
  typedef struct packed {
    logic fast_tick;
    logic slow_tick;
    logic [2:0] ep;
    logic dac;
    logic gpio;
  } misc_src_t;
  typedef enum logic [1:0] {
    SVC_IDLE = 2'b00,
    SVC_CALL = 2'b01,
    SVC_JUMP = 2'b10
  } misc_svc_t;
endpackage

// File: hdl/misc_top.sv
// processor status, interrupt latches, acknowledge and vectoring
`timescale 1ns/1ps
`default_nettype none
`include "misc_regs.svh"
module misc_top #(
  parameter int WAKE_SHORT_CYC =
    (`MISC_WAKE_SHORT_NS * 1000 + `MISC_CLK_PS - 1) / `MISC_CLK_PS,
  parameter int WAKE_LONG_CYC =
    (`MISC_WAKE_LONG_NS / 1000) * (1000000 / `MISC_CLK_PS)
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic wdt_reset,
  input wire misc_pkg::misc_cpu_t cpu,
  input wire misc_pkg::misc_src_t src,
  input wire logic bus_activity,
  input wire logic dp_in,
  input wire logic dm_in,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic run,
  output logic suspend,
  output logic gie,
  output logic call_req,
  output logic [15:0] vector,
  output logic svc_busy
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [3:0] first_set(input logic [11:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 11; i >= 1; i--) begin
      if (v[i]) begin
        n = 4'(i);
      end
    end
    return n;
  endfunction

  function automatic logic [15:0] vec_addr(input logic [3:0] n);
    return {11'h000, n, 1'b0};
  endfunction

  logic step_reg, pup_reg, busrst_reg, wdt_reg, pend_reg;
  logic [7:0] gie_en_reg;
  logic [2:0] ep_en_reg;
  logic [11:0] latch_reg;
  logic [11:0] en_mask, active, set_vec, clr_vec;
  logic ack, wr_psc, sleep_req, sleep_ok, wake, waking_reg;
  logic [24:0] wake_cnt_reg;
  logic dp_s1, dp_s2, dm_s1, dm_s2;
  logic [10:0] se0_cnt_reg;
  logic se0_hit;
  misc_pkg::misc_svc_t svc_reg;
  logic [3:0] svc_cnt_reg;

  // ****************************************
  // masking and recognition
  // ****************************************
  // enable per source
  assign en_mask = {gie_en_reg[6], gie_en_reg[5], 3'h0, ep_en_reg,
                    gie_en_reg[2:0], 1'b0};
  assign active = latch_reg & en_mask;
  assign ack = cpu.last && gie && (|active) && run && !suspend &&
               svc_reg == misc_pkg::SVC_IDLE;
  assign wr_psc = io_wr && io_addr == `MISC_PSC_ADDR;
  assign sleep_req = wr_psc && io_wdata[`MISC_SUSP];
  // refuse sleep if already something to wake on
  assign sleep_ok = sleep_req && !bus_activity && !(|active);
  assign wake = bus_activity || (|active);

  // ****************************************
  // bus reset detector
  // ****************************************
  // pins are asynchronous to the cpu clock
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dp_s1 <= 1'b1;
      dp_s2 <= 1'b1;
      dm_s1 <= 1'b1;
      dm_s2 <= 1'b1;
    end else begin
      dp_s1 <= dp_in;
      dp_s2 <= dp_s1;
      dm_s1 <= dm_in;
      dm_s2 <= dm_s1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      se0_cnt_reg <= 11'h000;
    end else if (dp_s2 || dm_s2) begin
      se0_cnt_reg <= 11'h000;
    end else if (se0_cnt_reg <= 11'(`MISC_SE0_CYC)) begin
      se0_cnt_reg <= se0_cnt_reg + 11'h001;
    end
  end
  // strictly longer than 8 us, one event per reset
  assign se0_hit = !dp_s2 && !dm_s2 && se0_cnt_reg == 11'(`MISC_SE0_CYC);

  // ****************************************
  // interrupt latches
  // ****************************************
  assign set_vec = {src.gpio, src.dac, 3'h0, src.ep, src.slow_tick,
                    src.fast_tick, se0_hit, 1'b0};
  always_comb begin
    clr_vec = 12'h000;
    if (ack) begin
      clr_vec[first_set(active)] = 1'b1;
    end
  end

  // new event wins over the acknowledge clear
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      latch_reg <= 12'h000;
    end else if (wdt_reset) begin
      latch_reg <= 12'h000;
    end else begin
      latch_reg <= (latch_reg & ~clr_vec) | set_vec;
    end
  end

  // ****************************************
  // enable registers
  // ****************************************
  // cleared by any reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gie_en_reg <= 8'h00;
      ep_en_reg <= 3'h0;
    end else if (wdt_reset) begin
      gie_en_reg <= 8'h00;
      ep_en_reg <= 3'h0;
    end else if (io_wr && io_addr == `MISC_GIE_ADDR) begin
      gie_en_reg <= io_wdata;
    end else if (io_wr && io_addr == `MISC_EPEN_ADDR) begin
      ep_en_reg <= io_wdata[2:0];
    end
  end

  // internal enable, never touched by a register write
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gie <= 1'b0;
    end else if (wdt_reset) begin
      gie <= 1'b0;
    end else if (ack) begin
      gie <= 1'b0;
    end else if (cpu.last && cpu.di) begin
      gie <= 1'b0;
    end else if (cpu.last && (cpu.ei || cpu.irq_return_instruction)) begin
      gie <= 1'b1;
    end
  end

  // ****************************************
  // status and control register
  // ****************************************
  // power-on value, watchdog value
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      {wdt_reg, busrst_reg, pup_reg, step_reg, run} <= 5'b00101;
    end else if (wdt_reset) begin
      // watchdog sets its flag, clears power-up
      {wdt_reg, busrst_reg, pup_reg, step_reg, run} <= 5'b10001;
    end else begin
      if (wr_psc) begin
        // firmware keeps run written as one
        run <= io_wdata[`MISC_RUN];
        step_reg <= io_wdata[`MISC_STEP];
        pup_reg <= io_wdata[`MISC_PUP];
        wdt_reg <= io_wdata[`MISC_WDT];
        busrst_reg <= io_wdata[`MISC_BUSRST] | se0_hit;
      end else if (se0_hit) begin
        busrst_reg <= 1'b1;
      end
      // single step stops after one instruction
      if (cpu.last && run && (cpu.halt || step_reg)) begin
        run <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pend_reg <= 1'b0;
    end else if (wdt_reset || ack) begin
      pend_reg <= 1'b0;
    end else if (cpu.last && (|active)) begin
      pend_reg <= 1'b1;
    end
  end

  // ****************************************
  // suspend and start-up timer
  // ****************************************
  // long start-up while the power-up flag is set (power-on or a write); trades wake speed for
  // oscillator settling
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      suspend <= 1'b0;
      waking_reg <= 1'b0;
      wake_cnt_reg <= 25'h000_0000;
    end else if (wdt_reset) begin
      suspend <= 1'b0;
      waking_reg <= 1'b0;
      wake_cnt_reg <= 25'h000_0000;
    end else if (!suspend) begin
      suspend <= sleep_ok;
    end else if (!waking_reg) begin
      if (wake) begin
        waking_reg <= 1'b1;
        // power-up flag picks the start-up time
        wake_cnt_reg <= pup_reg ? 25'(WAKE_LONG_CYC - 1) :
                                  25'(WAKE_SHORT_CYC - 1);
      end
    end else if (wake_cnt_reg == 25'h000_0000) begin
      suspend <= 1'b0;
      waking_reg <= 1'b0;
    end else begin
      wake_cnt_reg <= wake_cnt_reg - 25'h000_0001;
    end
  end

  // ****************************************
  // acknowledge call and vector jump
  // ****************************************
  // call then jump cycle budget
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      svc_reg <= misc_pkg::SVC_IDLE;
      svc_cnt_reg <= 4'h0;
    end else if (wdt_reset) begin
      svc_reg <= misc_pkg::SVC_IDLE;
      svc_cnt_reg <= 4'h0;
    end else begin
      case (svc_reg)
        misc_pkg::SVC_IDLE: begin
          if (ack) begin
            svc_reg <= misc_pkg::SVC_CALL;
            svc_cnt_reg <= 4'(`MISC_CALL_CYC - 1);
          end
        end
        misc_pkg::SVC_CALL: begin
          if (svc_cnt_reg == 4'h0) begin
            svc_reg <= misc_pkg::SVC_JUMP;
            svc_cnt_reg <= 4'(`MISC_JMP_CYC - 1);
          end else begin
            svc_cnt_reg <= svc_cnt_reg - 4'h1;
          end
        end
        misc_pkg::SVC_JUMP: begin
          if (svc_cnt_reg == 4'h0) begin
            svc_reg <= misc_pkg::SVC_IDLE;
          end else begin
            svc_cnt_reg <= svc_cnt_reg - 4'h1;
          end
        end
        default: begin
          svc_reg <= misc_pkg::SVC_IDLE;
        end
      endcase
    end
  end

  // call_req tells the core to push counter and flags
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      call_req <= 1'b0;
      vector <= 16'h0000;
      svc_busy <= 1'b0;
    end else begin
      call_req <= ack;
      svc_busy <= ack || (svc_reg == misc_pkg::SVC_CALL) ||
                  (svc_reg == misc_pkg::SVC_JUMP && svc_cnt_reg != 4'h0);
      if (wdt_reset) begin
        vector <= 16'h0000;
      end else if (ack) begin
        vector <= vec_addr(first_set(active));
      end
    end
  end

  // ****************************************
  // register read port
  // ****************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      io_rdata <= 8'h00;
    end else if (io_rd) begin
      case (io_addr)
        `MISC_GIE_ADDR: io_rdata <= gie_en_reg;
        `MISC_EPEN_ADDR: io_rdata <= {5'h00, ep_en_reg};
        `MISC_PSC_ADDR: io_rdata <= {pend_reg, wdt_reg, busrst_reg,
                                     pup_reg, suspend, gie, step_reg, run};
        default: io_rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_call;
    svc_busy [*5] ##1 svc_busy [*5];
  endsequence
  sequence s_jump;
    svc_busy [*5] ##1 !svc_busy;
  endsequence

  a_halt_stops_run: assert property (
    cpu.last && cpu.halt && run && !wdt_reset |=> !run [*2])
    else $error("halt did not stop run");
  a_step_one_instr: assert property (
    cpu.last && step_reg && run && !wdt_reset |=> !run)
    else $error("single step kept running");
  a_gie_write_none: assert property (
    wr_psc && !cpu.last && !ack && !wdt_reset |=> gie == $past(gie))
    else $error("register write changed enable");
  a_sleep_refused: assert property (
    !suspend && sleep_req && bus_activity |=> !suspend)
    else $error("sleep accepted with bus activity");
  a_busrst_flag: assert property (
    se0_hit && !wdt_reset |=> busrst_reg && latch_reg[1])
    else $error("bus reset not flagged");
  a_wdt_value: assert property (
    wdt_reset |=> {wdt_reg, busrst_reg, pup_reg, suspend, gie, step_reg,
                   run} == 7'h41 && ep_en_reg == 3'h0)
    else $error("watchdog reset value wrong");
  a_ack_order: assert property (
    ack && !wdt_reset |=> !gie && call_req && !pend_reg)
    else $error("acknowledge sequence wrong");
  a_ack_latency: assert property (disable iff (!rst_b || wdt_reset)
    ack |=> s_call ##1 s_jump)
    else $error("call and jump cycles wrong");
  a_ack_enabled: assert property (
    ack |=> $past(ep_en_reg[1]) || vector != 16'h000a)
    else $error("masked source acknowledged");
  a_vector_prio: assert property (
    ack && !wdt_reset && active[1] |=> vector == 16'h0002)
    else $error("bus reset not first");
endmodule
`default_nettype wire

// File: sim/misc_core_model.sv
// cpu core model: instruction end marker, decoded ops and call depth
`timescale 1ns/1ps
`default_nettype none
module misc_core_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [3:0] op,
  input wire logic call_req,
  output misc_pkg::misc_cpu_t cpu,
  output logic [3:0] depth
);
  logic [1:0] phase_reg;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // ops hold for the whole instruction; only the last cycle counts
  assign cpu = {phase_reg == 2'h3, op};

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      depth <= 4'h0;
    end else if (call_req) begin
      depth <= depth + 4'h1;
    end else if (cpu.last && cpu.irq_return_instruction && depth != 4'h0) begin
      depth <= depth - 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: sim/misc_top_tb.sv
// self-checking bench for the status and interrupt control block
`timescale 1ns/1ps
`default_nettype none
`include "misc_regs.svh"
module misc_top_tb;
  typedef struct {
    logic [7:0] a;
    logic [7:0] w;
    logic [7:0] m;
    logic [7:0] e;
  } misc_row_t;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic wdt_reset = 1'b0;
  logic [3:0] op = 4'h0;
  misc_pkg::misc_cpu_t cpu;
  misc_pkg::misc_src_t src = '0;
  logic bus_activity = 1'b0;
  logic dp_in = 1'b1;
  logic dm_in = 1'b1;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_addr = 8'h00;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata;
  logic run;
  logic suspend;
  logic gie;
  logic call_req;
  logic svc_busy;
  logic [15:0] vector;
  logic [3:0] depth;
  logic [7:0] d;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  misc_row_t rows [6] = '{
    '{`MISC_PSC_ADDR, 8'h15, 8'hff, `MISC_PSC_POR},
    '{`MISC_EPEN_ADDR, 8'hff, 8'h07, 8'h07},
    '{`MISC_EPEN_ADDR, 8'h00, 8'h07, 8'h00},
    '{`MISC_GIE_ADDR, 8'h61, 8'h61, 8'h61},
    '{`MISC_GIE_ADDR, 8'h00, 8'hff, 8'h00},
    '{8'h30, 8'ha5, 8'hff, 8'h00}
  };

  always #2.5 clock = ~clock;

  misc_top #(.WAKE_SHORT_CYC(5), .WAKE_LONG_CYC(20)) dut (
    .clock(clock), .rst_b(rst_b), .wdt_reset(wdt_reset), .cpu(cpu),
    .src(src), .bus_activity(bus_activity), .dp_in(dp_in), .dm_in(dm_in),
    .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .run(run), .suspend(suspend), .gie(gie),
    .call_req(call_req), .vector(vector), .svc_busy(svc_busy)
  );

  misc_core_model core (
    .clock(clock), .rst_b(rst_b), .op(op), .call_req(call_req),
    .cpu(cpu), .depth(depth)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one-cycle port strobe; read data lands in d
  task automatic acc(input logic rd, input logic [7:0] a,
                     input logic [7:0] w);
    @(posedge clock);
    #1;
    io_rd = rd;
    io_wr = !rd;
    io_addr = a;
    io_wdata = w;
    @(posedge clock);
    #1;
    io_rd = 1'b0;
    io_wr = 1'b0;
    d = io_rdata;
  endtask

  // op = {halt, di, ei, irq_return_instruction}, held until the instruction's last edge
  task automatic instr(input logic [3:0] o);
    op = o;
    while (cpu.last !== 1'b1) begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    #1;
    op = 4'h0;
  endtask

  task automatic wait_call(input logic [15:0] v);
    n = 0;
    while (call_req !== 1'b1 && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(call_req, 1'b1);
    chk(vector, v);
    chk(gie, 1'b0);
    n = 0;
    while (svc_busy === 1'b1 && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(16'(n), 16'(`MISC_CALL_CYC + `MISC_JMP_CYC));
  endtask

  task automatic cycles_wait(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      tally_and_finish;
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    cycles_wait(20);
    rst_b = 1'b1;
    acc(1'b1, `MISC_PSC_ADDR, 8'h00);
    chk(d, `MISC_PSC_POR);
    acc(1'b1, `MISC_EPEN_ADDR, 8'h00);
    chk(d & 8'h07, 8'h00);
    foreach (rows[i]) begin
      acc(1'b0, rows[i].a, rows[i].w);
      acc(1'b1, rows[i].a, 8'h00);
      chk(d & rows[i].m, rows[i].e);
    end
    // priority and nesting: ep1 masked until its enable is written, then taken
    acc(1'b0, `MISC_EPEN_ADDR, 8'h05);
    @(posedge clock);
    #1;
    src.ep = 3'h7;
    @(posedge clock);
    #1;
    src.ep = 3'h0;
    instr(4'h2);
    wait_call(16'h0008);
    instr(4'h2);
    wait_call(16'h000c);
    chk(depth, 4'h2);
    instr(4'h2);
    cycles_wait(20);
    chk(call_req | svc_busy, 1'b0);
    instr(4'h4);
    chk(gie, 1'b0);
    instr(4'h1);
    chk(gie, 1'b1);
    chk(depth, 4'h1);
    instr(4'h4);
    acc(1'b0, `MISC_EPEN_ADDR, 8'h07);
    cycles_wait(8);
    acc(1'b1, `MISC_PSC_ADDR, 8'h00);
    chk(d[7], 1'b1);
    instr(4'h2);
    wait_call(16'h000a);
    acc(1'b1, `MISC_PSC_ADDR, 8'h00);
    chk(d[7], 1'b0);
    // single line low is not a bus reset, both low is
    dp_in = 1'b0;
    cycles_wait(1700);
    acc(1'b1, `MISC_PSC_ADDR, 8'h00);
    chk(d[5], 1'b0);
    dm_in = 1'b0;
    cycles_wait(1700);
    dp_in = 1'b1;
    dm_in = 1'b1;
    acc(1'b1, `MISC_PSC_ADDR, 8'h00);
    chk(d[5], 1'b1);
    chk(run, 1'b1);
    // bus reset latch waited masked; enabling it now takes vector one
    acc(1'b0, `MISC_GIE_ADDR, 8'h01);
    instr(4'h2);
    wait_call(16'h0002);
    // suspend refused under activity, then taken and woken
    bus_activity = 1'b1;
    acc(1'b0, `MISC_PSC_ADDR, 8'h19);
    cycles_wait(2);
    chk(suspend, 1'b0);
    bus_activity = 1'b0;
    acc(1'b0, `MISC_PSC_ADDR, 8'h19);
    cycles_wait(2);
    chk(suspend, 1'b1);
    bus_activity = 1'b1;
    cycles_wait(1);
    bus_activity = 1'b0;
    n = 0;
    while (suspend === 1'b1 && n < 60) begin
      cycles_wait(1);
      n++;
    end
    chk(n >= 19 && n <= 24, 1'b1);
    // step, then watchdog restart, then halt
    acc(1'b0, `MISC_PSC_ADDR, 8'h13);
    cycles_wait(10);
    chk(run, 1'b0);
    wdt_reset = 1'b1;
    cycles_wait(1);
    wdt_reset = 1'b0;
    cycles_wait(2);
    acc(1'b1, `MISC_PSC_ADDR, 8'h00);
    chk(d, `MISC_PSC_WDT);
    acc(1'b1, `MISC_EPEN_ADDR, 8'h00);
    chk(d & 8'h07, 8'h00);
    // power-up flag now clear: short start-up after wake
    acc(1'b0, `MISC_PSC_ADDR, 8'h09);
    chk(suspend, 1'b1);
    bus_activity = 1'b1;
    cycles_wait(1);
    bus_activity = 1'b0;
    n = 0;
    while (suspend === 1'b1 && n < 60) begin
      cycles_wait(1);
      n++;
    end
    chk(n >= 4 && n <= 9, 1'b1);
    instr(4'h8);
    cycles_wait(12);
    chk(run, 1'b0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
